/* File: hw/idle_gov_pkg.sv */
// Package for the package idle-state governor: state codes, limits and carriers
package idle_gov_pkg;

    // Package idle states, shallow to deep
    typedef enum logic [3:0] {
        PKG_C0  = 4'h0,
        PKG_C2  = 4'h2,
        PKG_C3  = 4'h3,
        PKG_C6  = 4'h6,
        PKG_C7  = 4'h7,
        PKG_C8  = 4'h8,
        PKG_C9  = 4'h9,
        PKG_C10 = 4'hA
    } pkg_state_t;

    // Type-C subsystem power states
    typedef enum logic [1:0] {
        PORT_ACTIVE        = 2'h0,
        PORT_ATTACHED_IDLE = 2'h1,
        PORT_DETACHED_LITE = 2'h2,
        PORT_DETACHED_DEEP = 2'h3
    } port_state_t;

    // Cache flush FSM
    typedef enum logic [1:0] {
        LLC_FULL     = 2'b00,
        LLC_FLUSHING = 2'b01,
        LLC_EMPTY    = 2'b10,
        LLC_REGROW   = 2'b11
    } llc_state_t;

    localparam logic [3:0] CORE_C7     = 4'h7;
    localparam int         LLC_WAYS    = 16;
    localparam logic [4:0] LLC_WAYS_W  = 5'h10;
    localparam logic [4:0] FLUSH_STEP  = 5'h02;
    localparam logic [4:0] REGROW_STEP = 5'h01;
    localparam logic [4:0] WAYS_ZERO   = 5'h00;
    localparam int         NUM_CORES   = 4;
    localparam int         NUM_PIPES   = 4;
    localparam logic [6:0] BL_MAX      = 7'h64;  // 101 levels: 0..100
    localparam logic [6:0] BL_ZERO     = 7'h00;
    localparam logic [6:0] DIFF_LIMIT  = 7'h10;

    // Type-C port status from the subsystem
    typedef struct packed {
        port_state_t state;
        logic        attached;
        logic        host_ctrl_d3;
        logic        tunnel_idle;
        logic        pcie_inactive;
        logic        io_mgr_active;
    } port_status_t;

    // Display configuration
    typedef struct packed {
        logic        single_display;
        logic        res_in_range;
        logic        self_refresh_en;
        logic        embedded_panel;
        logic        scaling_on;
    } display_cfg_t;

endpackage

/* File: hw/idle_state_governor.sv */
// Package idle-state governor: demotion, cache flush, state save, memory and display power
// Operation
// - Grant may be shallower than requested state
// - Demotion uses latency, energy and tolerance
// - Flush cache only when all cores deep
// - Flush gradually or at once per hint
// - Regrow cache ways gradually on wake
// - Save state to memory at C6+
// - Power-gate save arrays once saved
// - Machine check on corrupted restored state
// - Display limit C10 with single display, resolution in range and self refresh, else C8
// - Active port limits package to C0-C3
// - Attached idle port allows C6-C10
// - Detached light port allows C3-C10
// - Detached deep port allows C6-C10
// - Memory self-refresh only at C3 or deeper
// - Interrupt on significant image change
// - Dim backlight in same update as enhancement
// - Power off inactive pipes in single-pipe mode
// - Backlight has 101 brightness levels
module idle_state_governor
    import idle_gov_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire logic                  rst_b_in,
    input  wire pkg_state_t            req_state_in,
    input  wire logic [NUM_CORES*4-1:0] core_cstate_in,
    input  wire logic                  wait_hint_substate_in,
    input  wire pkg_state_t            latency_limit_in,
    input  wire logic                  energy_ok_in,
    input  wire port_status_t          type_c_subsystem_in,
    input  wire display_cfg_t          display_in,
    input  wire logic                  state_save_to_memory_en_in,
    input  wire logic                  save_done_in,
    input  wire logic                  restore_valid_in,
    input  wire logic                  restore_corrupt_in,
    input  wire logic                  mem_traffic_busy_in,
    input  wire logic                  single_pipe_low_power_in,
    input  wire logic [NUM_PIPES-1:0]  pipe_active_in,
    input  wire logic                  image_update_in,
    input  wire logic [6:0]            image_luma_in,
    input  wire logic [6:0]            enhance_gain_in,
    input  wire logic [6:0]            backlight_req_in,
    output logic                       grant_valid_out,
    output pkg_state_t                 grant_state_out,
    output logic [4:0]                 llc_ways_out,
    output logic                       save_to_memory_out,
    output logic                       save_arrays_gated_out,
    output logic                       machine_check_out,
    output logic                       mem_self_refresh_out,
    output logic [NUM_PIPES-1:0]       pipe_power_out,
    output logic                       image_change_irq_out,
    output logic [6:0]                 enhance_gain_out,
    output logic [6:0]                 backlight_level_out
);

    // Limits from each source
    pkg_state_t port_limit;
    pkg_state_t disp_limit;
    pkg_state_t lat_limit;
    pkg_state_t min_a;
    pkg_state_t min_b;
    pkg_state_t grant_nxt;
    pkg_state_t grant_r;

    wire port_ok_idle = type_c_subsystem_in.host_ctrl_d3 && type_c_subsystem_in.tunnel_idle
                        && type_c_subsystem_in.pcie_inactive;

    always_comb begin
        port_limit = PKG_C3;
        case (type_c_subsystem_in.state)
            PORT_ACTIVE:        port_limit = PKG_C3;
            PORT_ATTACHED_IDLE: port_limit = port_ok_idle ? PKG_C10 : PKG_C3;
            PORT_DETACHED_LITE: port_limit = type_c_subsystem_in.host_ctrl_d3
                                             ? PKG_C10 : PKG_C3;
            PORT_DETACHED_DEEP: port_limit = (port_ok_idle && !type_c_subsystem_in.attached
                                              && !type_c_subsystem_in.io_mgr_active)
                                             ? PKG_C10 : PKG_C3;
            default:            port_limit = PKG_C3;
        endcase
    end

    // Only the documented single-display case is known deep; others stay at C8
    assign disp_limit = (display_in.single_display && display_in.res_in_range
                         && display_in.self_refresh_en) ? PKG_C10 : PKG_C8;

    // Low entry/exit energy benefit keeps the package out of C9/C10
    assign lat_limit = (!energy_ok_in && latency_limit_in > PKG_C8)
                       ? PKG_C8 : latency_limit_in;

    assign min_a     = (req_state_in < port_limit) ? req_state_in : port_limit;
    assign min_b     = (disp_limit < lat_limit) ? disp_limit : lat_limit;
    assign grant_nxt = (min_a < min_b) ? min_a : min_b;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            grant_r <= PKG_C0;
        end else begin
            grant_r <= grant_nxt;
        end
    end

    assign grant_state_out = grant_r;
    assign grant_valid_out = 1'b1;

    // Cache sizing
    llc_state_t llc_r;
    llc_state_t llc_nxt;
    logic [4:0] ways_r;
    logic [4:0] ways_nxt;
    logic [NUM_CORES-1:0] core_deep;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CORES; gi++) begin : g_core
            assign core_deep[gi] = core_cstate_in[gi*4 +: 4] >= CORE_C7;
        end
    endgenerate

    wire all_deep   = &core_deep;
    wire [4:0] flush_step = (ways_r > FLUSH_STEP) ? 5'(ways_r - FLUSH_STEP) : WAYS_ZERO;
    wire [4:0] grow = (ways_r + REGROW_STEP > LLC_WAYS_W) ? LLC_WAYS_W
                                                          : 5'(ways_r + REGROW_STEP);

    always_comb begin
        llc_nxt  = llc_r;
        ways_nxt = ways_r;
        case (llc_r)
            LLC_FULL: begin
                if (all_deep) begin
                    llc_nxt = LLC_FLUSHING;
                end
            end
            LLC_FLUSHING: begin
                if (!all_deep) begin
                    // Nothing flushed yet: back to full, a regrow from full would only clamp at the top
                    llc_nxt = (ways_r == LLC_WAYS_W) ? LLC_FULL : LLC_REGROW;
                end else if (wait_hint_substate_in) begin
                    ways_nxt = WAYS_ZERO;
                    llc_nxt  = LLC_EMPTY;
                end else begin
                    ways_nxt = 5'(flush_step);
                    if (flush_step == WAYS_ZERO) begin
                        llc_nxt = LLC_EMPTY;
                    end
                end
            end
            LLC_EMPTY: begin
                if (!all_deep) begin
                    llc_nxt = LLC_REGROW;
                end
            end
            LLC_REGROW: begin
                if (all_deep) begin
                    llc_nxt = LLC_FLUSHING;
                end else begin
                    ways_nxt = grow;
                    if (grow == LLC_WAYS_W) begin
                        llc_nxt = LLC_FULL;
                    end
                end
            end
            default: llc_nxt = LLC_FULL;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            llc_r  <= LLC_FULL;
            ways_r <= LLC_WAYS_W;
        end else begin
            llc_r  <= llc_nxt;
            ways_r <= ways_nxt;
        end
    end

    assign llc_ways_out = ways_r;

    // State save to memory
    logic save_r;
    logic gated_r;
    logic mc_r;
    wire  deep_c6 = grant_r >= PKG_C6;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            save_r  <= 1'b0;
            gated_r <= 1'b0;
            mc_r    <= 1'b0;
        end else begin
            save_r  <= state_save_to_memory_en_in && deep_c6;
            gated_r <= save_r && (save_done_in || gated_r);
            // Sticky until reset: corrupted context cannot be trusted further
            mc_r    <= mc_r || (restore_valid_in && restore_corrupt_in);
        end
    end

    assign save_to_memory_out    = save_r;
    assign save_arrays_gated_out = gated_r;
    assign machine_check_out     = mc_r;

    // Memory self-refresh
    logic sr_r;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sr_r <= 1'b0;
        end else begin
            sr_r <= (grant_r >= PKG_C3) && !mem_traffic_busy_in;
        end
    end
    assign mem_self_refresh_out = sr_r;

    // Display pipes
    wire lp_ok = single_pipe_low_power_in && display_in.single_display
                 && display_in.embedded_panel && !display_in.scaling_on;
    logic [NUM_PIPES-1:0] pipe_r;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pipe_r <= '1;
        end else begin
            pipe_r <= lp_ok ? pipe_active_in : '1;
        end
    end
    assign pipe_power_out = pipe_r;

    // Image analysis and backlight
    logic [6:0] luma_r;
    logic       irq_r;
    logic [6:0] gain_r;
    logic [6:0] bl_r;
    wire  [6:0] luma_diff = (image_luma_in > luma_r) ? 7'(image_luma_in - luma_r)
                                                     : 7'(luma_r - image_luma_in);
    wire  [6:0] bl_clip   = (backlight_req_in > BL_MAX) ? BL_MAX : backlight_req_in;
    wire  [6:0] bl_dim    = (bl_clip > enhance_gain_in) ? 7'(bl_clip - enhance_gain_in)
                                                        : BL_ZERO;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            luma_r <= BL_ZERO;
            irq_r  <= 1'b0;
            gain_r <= BL_ZERO;
            bl_r   <= BL_ZERO;
        end else begin
            irq_r <= image_update_in && (luma_diff >= DIFF_LIMIT);
            if (image_update_in) begin
                luma_r <= image_luma_in;
            end
            // Gain and dimming share one register update so no frame sees one alone
            gain_r <= enhance_gain_in;
            bl_r   <= bl_dim;
        end
    end

    assign image_change_irq_out = irq_r;
    assign enhance_gain_out     = gain_r;
    assign backlight_level_out  = bl_r;

    // Checks
    a_port_active_limit: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        type_c_subsystem_in.state == PORT_ACTIVE |=> grant_state_out <= PKG_C3)
        else $error("active port let package go deeper than C3");
    a_disp_limit_c8: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !display_in.self_refresh_en |=> grant_state_out <= PKG_C8)
        else $error("display limit exceeded without self refresh");
    a_grant_le_req: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        1'b1 |=> grant_state_out <= $past(req_state_in))
        else $error("grant deeper than request");
    a_flush_needs_deep: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        llc_r == LLC_FULL && !all_deep |=> llc_r == LLC_FULL)
        else $error("flush started without all cores deep");
    a_flush_at_once: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        llc_r == LLC_FLUSHING && all_deep && wait_hint_substate_in |=> llc_ways_out == WAYS_ZERO)
        else $error("single-step flush left ways");
    a_regrow_gradual: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        llc_r == LLC_REGROW && !all_deep |=> llc_ways_out == $past(llc_ways_out) + REGROW_STEP)
        else $error("regrow not gradual");
    a_save_deep: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        save_to_memory_out |-> $past(grant_state_out) >= PKG_C6)
        else $error("state saved above C6");
    a_gate_after_save: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        save_arrays_gated_out |-> $past(save_to_memory_out))
        else $error("arrays gated before save");
    a_mc_sticky: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        restore_valid_in && restore_corrupt_in |=> machine_check_out [*2])
        else $error("machine check missing");
    a_self_refresh: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        mem_self_refresh_out |-> $past(grant_state_out) >= PKG_C3)
        else $error("self refresh above C3");
    a_backlight_range: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        backlight_level_out <= BL_MAX)
        else $error("backlight out of range");
    a_pipe_off: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        lp_ok |=> pipe_power_out == $past(pipe_active_in))
        else $error("inactive pipe left powered");

    // Each limit bounds the grant on its own, whatever the others allow; then flush, regrow, save, machine check, refresh, irq, dimming and pipe checks
    a_attached_idle_cap: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        type_c_subsystem_in.state == PORT_ATTACHED_IDLE && !port_ok_idle |=> grant_state_out <= PKG_C3)
        else $error("attached idle port without idle controllers let package go deep");
    a_energy_cap: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !energy_ok_in |=> grant_state_out <= PKG_C8)
        else $error("low energy benefit did not cap the grant");
    a_latency_cap: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        1'b1 |=> grant_state_out <= $past(latency_limit_in))
        else $error("grant deeper than latency tolerance");
    a_flush_step: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        llc_r == LLC_FLUSHING && all_deep && !wait_hint_substate_in && llc_ways_out > FLUSH_STEP
        |=> llc_ways_out == $past(llc_ways_out) - FLUSH_STEP)
        else $error("gradual flush did not take one step");
    a_flush_last_step: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        llc_r == LLC_FLUSHING && all_deep && llc_ways_out <= FLUSH_STEP |=> llc_ways_out == WAYS_ZERO)
        else $error("flush stopped short of empty");
    a_regrow_full: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        llc_r == LLC_REGROW && !all_deep && llc_ways_out == LLC_WAYS_W - REGROW_STEP |=> llc_r == LLC_FULL)
        else $error("regrow did not end full");
    a_save_when_deep: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        state_save_to_memory_en_in && grant_state_out >= PKG_C6 |=> save_to_memory_out)
        else $error("state not saved to memory in deep state");
    a_mc_clean: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !machine_check_out && !(restore_valid_in && restore_corrupt_in) |=> !machine_check_out)
        else $error("machine check without corrupted restore");
    a_refresh_busy: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        mem_traffic_busy_in |=> !mem_self_refresh_out)
        else $error("self refresh while memory traffic busy");
    a_irq_needs_update: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        image_change_irq_out |-> $past(image_update_in))
        else $error("image change interrupt without update");
    a_gain_with_dim: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        1'b1 |=> enhance_gain_out == $past(enhance_gain_in) && backlight_level_out <= $past(backlight_req_in))
        else $error("enhancement and dimming not in one update");
    a_pipes_all_on: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !lp_ok |=> &pipe_power_out)
        else $error("pipe powered off outside single-pipe mode");

    c_deep_grant: cover property (@(posedge clk_in) disable iff (!rst_b_in) grant_state_out == PKG_C10);
    c_flush_empty: cover property (@(posedge clk_in) disable iff (!rst_b_in) llc_r == LLC_EMPTY);
    c_regrow_full: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        llc_r == LLC_REGROW ##1 llc_r == LLC_FULL);
    c_irq: cover property (@(posedge clk_in) disable iff (!rst_b_in) image_change_irq_out);
    c_pipe_single: cover property (@(posedge clk_in) disable iff (!rst_b_in) !(&pipe_power_out));

endmodule

/* File: test/platform_side_model.sv */
// Model of the operating system and the Type-C subsystem that feed the governor
module platform_side_model
    import idle_gov_pkg::*;
(
    input  wire port_state_t  port_cmd_in,
    input  wire logic         standby_in,
    input  wire pkg_state_t   os_req_in,
    input  wire logic         pcie_fault_in,
    output port_status_t      port_status_out,
    output pkg_state_t        req_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic not_active;

    // Controllers only settle into D3 once the port leaves its active state
    assign not_active = (port_cmd_in != PORT_ACTIVE);

    always_comb begin
        port_status_out.state         = port_cmd_in;
        port_status_out.attached      = (port_cmd_in == PORT_ACTIVE) || (port_cmd_in == PORT_ATTACHED_IDLE);
        port_status_out.host_ctrl_d3  = not_active;
        port_status_out.tunnel_idle   = not_active;
        // A stuck PCIe path lets the bench break the attached idle conditions
        port_status_out.pcie_inactive = not_active && !pcie_fault_in;
        port_status_out.io_mgr_active = (port_cmd_in != PORT_DETACHED_DEEP);
        req_out                       = standby_in ? PKG_C10 : os_req_in;
    end
endmodule

/* File: test/package_idle_state_governor_bench.sv */
// Self-checking bench for the package idle-state governor
module package_idle_state_governor_bench
    import idle_gov_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic         clk, rst_b, standby, fault, hint, energy, save_en, save_done;
    logic         rv, rc, busy, single_pipe_low_power, upd, gv, save_o, gated, mc, msr, irq;
    pkg_state_t   os_req, lat, req, grant;
    port_state_t  port_cmd;
    port_status_t port_st;
    display_cfg_t disp;
    logic [15:0]  cores;
    logic [3:0]   pipes_act, pipes_pwr;
    logic [6:0]   luma, gain, bl_req, gain_o, bl_o;
    logic [4:0]   ways;
    int           failures, compares;

    platform_side_model i_far (.port_cmd_in(port_cmd), .standby_in(standby), .os_req_in(os_req),
        .pcie_fault_in(fault), .port_status_out(port_st), .req_out(req));

    idle_state_governor i_dut (.clk_in(clk), .rst_b_in(rst_b), .req_state_in(req), .core_cstate_in(cores),
        .wait_hint_substate_in(hint), .latency_limit_in(lat), .energy_ok_in(energy),
        .type_c_subsystem_in(port_st), .display_in(disp), .state_save_to_memory_en_in(save_en),
        .save_done_in(save_done), .restore_valid_in(rv), .restore_corrupt_in(rc),
        .mem_traffic_busy_in(busy), .single_pipe_low_power_in(single_pipe_low_power), .pipe_active_in(pipes_act),
        .image_update_in(upd), .image_luma_in(luma), .enhance_gain_in(gain), .backlight_req_in(bl_req),
        .grant_valid_out(gv), .grant_state_out(grant), .llc_ways_out(ways), .save_to_memory_out(save_o),
        .save_arrays_gated_out(gated), .machine_check_out(mc), .mem_self_refresh_out(msr),
        .pipe_power_out(pipes_pwr), .image_change_irq_out(irq), .enhance_gain_out(gain_o),
        .backlight_level_out(bl_o));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Self refresh follows the grant, so it is checked in every grant case
    task automatic grant_case(port_state_t p, pkg_state_t r, pkg_state_t l, logic e, logic psr, logic f,
                              pkg_state_t exp);
        @(posedge clk);
        port_cmd <= p;
        standby <= (r == PKG_C10);
        os_req <= r;
        lat <= l;
        energy <= e;
        disp.self_refresh_en <= psr;
        fault <= f;
        tick(4);
        check("grant", grant, exp);
        check("self_refresh", msr, exp >= PKG_C3);
    endtask

    // Steps are bounded per cycle so an all-at-once change is caught
    task automatic ways_run(logic [4:0] target, logic [4:0] step, logic up);
        logic [4:0] prev;
        logic       ok;
        int         i;
        ok = 1'b1;
        for (i = 0; i < 40 && ways !== target; i++) begin
            prev = ways;
            tick(1);
            if (up ? (ways > prev + step) : (prev > ways + step))
                ok = 1'b0;
        end
        check("ways_reach", ways, target);
        if (ways !== target)
            tally_and_finish();
        check("ways_step", ok, 1'b1);
    endtask

    task automatic pulse(logic [6:0] v, logic exp);
        @(posedge clk);
        upd <= 1'b1;
        luma <= v;
        @(posedge clk);
        upd <= 1'b0;
        #1;
        check("irq", irq, exp);
    endtask

    initial begin
        rst_b = 1'b0; standby = 1'b1; fault = 1'b0; hint = 1'b0; energy = 1'b1; save_en = 1'b1;
        save_done = 1'b0; rv = 1'b0; rc = 1'b0; busy = 1'b0; single_pipe_low_power = 1'b0; upd = 1'b0;
        os_req = PKG_C10; lat = PKG_C10; port_cmd = PORT_ACTIVE; disp = 5'h1E; cores = 16'h0000;
        pipes_act = 4'hF; luma = 7'h00; gain = 7'h00; bl_req = 7'h00;
        failures = 0; compares = 0;
        tick(10);
        check("reset_grant", grant, PKG_C0);
        check("reset_ways", ways, LLC_WAYS_W);
        @(posedge clk);
        rst_b <= 1'b1;
        grant_case(PORT_ACTIVE, PKG_C10, PKG_C10, 1'b1, 1'b1, 1'b0, PKG_C3);
        check("grant_valid", gv, 1'b1);
        grant_case(PORT_ATTACHED_IDLE, PKG_C10, PKG_C10, 1'b1, 1'b1, 1'b0, PKG_C10);
        grant_case(PORT_ATTACHED_IDLE, PKG_C10, PKG_C10, 1'b1, 1'b1, 1'b1, PKG_C3);
        grant_case(PORT_DETACHED_LITE, PKG_C10, PKG_C10, 1'b1, 1'b1, 1'b0, PKG_C10);
        grant_case(PORT_DETACHED_DEEP, PKG_C10, PKG_C10, 1'b1, 1'b0, 1'b0, PKG_C8);
        grant_case(PORT_DETACHED_DEEP, PKG_C10, PKG_C6, 1'b1, 1'b1, 1'b0, PKG_C6);
        grant_case(PORT_DETACHED_DEEP, PKG_C10, PKG_C10, 1'b0, 1'b1, 1'b0, PKG_C8);
        grant_case(PORT_DETACHED_DEEP, PKG_C2, PKG_C10, 1'b1, 1'b1, 1'b0, PKG_C2);
        grant_case(PORT_DETACHED_DEEP, PKG_C10, PKG_C10, 1'b1, 1'b1, 1'b0, PKG_C10);
        check("save", save_o, 1'b1);
        @(posedge clk);
        save_done <= 1'b1;
        busy <= 1'b1;
        tick(4);
        check("gated", gated, 1'b1);
        check("busy_refresh", msr, 1'b0);
        @(posedge clk);
        busy <= 1'b0;
        grant_case(PORT_ACTIVE, PKG_C10, PKG_C10, 1'b1, 1'b1, 1'b0, PKG_C3);
        check("save_shallow", save_o, 1'b0);
        @(posedge clk);
        rv <= 1'b1;
        rc <= 1'b1;
        tick(3);
        check("mcheck", mc, 1'b1);
        @(posedge clk);
        rc <= 1'b0;
        tick(3);
        check("mcheck_sticky", mc, 1'b1);
        // Only reset clears it; a clean restore afterwards must not raise it again
        @(posedge clk);
        rst_b <= 1'b0;
        tick(2);
        check("mcheck_reset", mc, 1'b0);
        @(posedge clk);
        rst_b <= 1'b1;
        tick(3);
        check("mcheck_clean", mc, 1'b0);
        $display("test grant and save done");
        @(posedge clk);
        cores <= 16'h7776;
        tick(10);
        check("ways_hold", ways, LLC_WAYS_W);
        @(posedge clk);
        cores <= 16'h7777;
        ways_run(WAYS_ZERO, FLUSH_STEP, 1'b0);
        @(posedge clk);
        cores <= 16'h0000;
        ways_run(LLC_WAYS_W, REGROW_STEP, 1'b1);
        @(posedge clk);
        hint <= 1'b1;
        cores <= 16'hAAAA;
        tick(4);
        check("ways_at_once", ways, WAYS_ZERO);
        @(posedge clk);
        cores <= 16'h0000;
        ways_run(LLC_WAYS_W, REGROW_STEP, 1'b1);
        $display("test cache sizing done");
        @(posedge clk);
        single_pipe_low_power <= 1'b1;
        pipes_act <= 4'h1;
        tick(3);
        check("pipes_single", pipes_pwr, 4'h1);
        @(posedge clk);
        single_pipe_low_power <= 1'b0;
        tick(3);
        check("pipes_all", pipes_pwr, 4'hF);
        pulse(7'h28, 1'b1);
        tick(1);
        check("irq_low", irq, 1'b0);
        pulse(7'h2D, 1'b0);
        pulse(7'h3D, 1'b1);
        @(posedge clk);
        bl_req <= 7'h5A;
        gain <= 7'h14;
        tick(1);
        check("backlight", bl_o, 7'h46);
        check("gain", gain_o, 7'h14);
        @(posedge clk);
        bl_req <= 7'h7F;
        gain <= 7'h00;
        tick(2);
        check("backlight_clip", bl_o, BL_MAX);
        $display("test display done");
        tally_and_finish();
    end
endmodule
